// ### rtl/pep_params.svh
/*
  Register offsets, reset values and widths for the port E pin block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PEP_PARAMS_SVH
`define PEP_PARAMS_SVH

// =====================================================================
// Register offsets (byte addresses on the plain register port)
`define PEP_OFF_OUTPUT_LATCH   8'h00
`define PEP_OFF_DIRECTION_BITS 8'h04
`define PEP_OFF_PIN_LEVEL_VIEW 8'h08
`define PEP_OFF_PULLUP_ENABLE  8'h0c
`define PEP_OFF_MODE_CTRL      8'h10

// =====================================================================
// Reset values
`define PEP_RST_OUTPUT_LATCH   8'h00
`define PEP_RST_DIRECTION_BITS 8'h00
`define PEP_RST_PULLUP_ENABLE  8'h00
`define PEP_RST_MODE_CTRL      8'h00

// =====================================================================
// Mode control field positions
`define PEP_MODE_LSB           0
`define PEP_MODE_MSB           2
`define PEP_EXPAND_BIT         3
`define PEP_WIDE_BUS_BIT       4
`define PEP_MODE_CTRL_MASK     8'h1f

// Value returned when the write-only direction register is read
`define PEP_UNDEF_READ         8'h00

`endif

// ### rtl/pep_pkg.sv
/*
  Types shared by the port E pin block.
  Assumes pep_params.svh is on the include path.
*/
`default_nettype none

package pep_pkg;
  `include "pep_params.svh"

  // =====================================================================
  // Pin function of the whole port
  typedef enum logic [2:0] {
    PEP_FN_PORT  = 3'b001,
    PEP_FN_DATA  = 3'b010,
    PEP_FN_RESET = 3'b100
  } pep_fn_e;

  // Power state reported by the system
  typedef enum logic [2:0] {
    PEP_PWR_RUN  = 3'b001,
    PEP_PWR_SSBY = 3'b010,
    PEP_PWR_HSBY = 3'b100
  } pep_pwr_e;
endpackage : pep_pkg

`default_nettype wire

// ### rtl/pep_bit.sv
/*
  One pin slice: read-back select, pin driver and pull-up decision.
  Assumes all inputs synchronous to mclk; pin_in, data_mode and pu_allowed arrive unregistered.
*/
`default_nettype none

module pep_bit
  import pep_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic latch_bit,
  input  wire logic dir_bit,
  input  wire logic pu_bit,
  input  wire logic pin_in,
  input  wire logic data_mode,
  input  wire logic pu_allowed,
  input  wire logic bus_out,
  input  wire logic bus_oe,
  output logic      view_bit,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_on
);

  logic next_pin_out;
  logic next_pin_oe;
  logic next_pullup_on;

  // =====================================================================
  // Read-back select
  assign view_bit = dir_bit ? latch_bit : pin_in;

  // =====================================================================
  // Pin driver and pull-up
  always_comb begin
    if (data_mode) begin
      next_pin_out = bus_out;
      next_pin_oe  = bus_oe;
    end else begin
      next_pin_out = latch_bit;
      next_pin_oe  = dir_bit;
    end
    // Pull-up only on an input pin; each slice decides alone
    next_pullup_on = pu_allowed & ~dir_bit & pu_bit;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      pullup_on <= 1'b0;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      pullup_on <= next_pullup_on;
    end
  end

endmodule : pep_bit

`default_nettype wire

// ### rtl/pep_port.sv
/*
  Eight-bit general-purpose port whose pins double as the low data byte.
  Assumes a plain register port, inputs synchronous to mclk, and an
  external bus controller that drives bus_dout/bus_doe in data mode.
*/
// Decided for this implementation: the placing of the registers and strobed register access.
// What this block does
// - Pin view read gives output latch if direction is 1, else pin level
// - Pin view register is read-only; writes change nothing
// - Pull-up enable resets to 0, read/write; 1 turns pull-up on for inputs
// - Pull-up enable acts only in 8-bit bus mode
// - Modes 1,2,4,5,6: port by direction if all 8-bit, else data bus
// - Modes 3,7: port if expansion off; else as modes 1,2,4,5,6
// - Each pin's pull-up is controlled independently
// - All pull-ups off during reset and hardware standby
// - 8-bit mode, run or software standby: pull-up on iff dir 0, enable 1
// - 16-bit bus mode keeps pull-ups off always
// - Output latch holds output value per bit, resets to 0
// - Direction register write-only, resets to 0, reads undefined
`default_nettype none
`include "pep_params.svh"

module pep_port
  import pep_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Power state
  input  wire logic             hw_standby,
  input  wire logic             sw_standby,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pullup_on,
  // External data bus
  input  wire logic [WIDTH-1:0] bus_dout,
  input  wire logic             bus_doe,
  output logic      [WIDTH-1:0] bus_din,
  output logic                  data_mode
);

  // =====================================================================
  // Parameter check
  if (WIDTH != 8) begin : g_bad_width
    $error("pep_port supports only WIDTH of 8");
  end
  // The decode takes a three-bit mode field and two flags above it; a
  // header that moves them into each other would silently alias modes
  if (`PEP_MODE_MSB - `PEP_MODE_LSB != 2) begin : g_bad_mode_field
    $error("pep_port needs a three-bit operating mode field");
  end
  if ((`PEP_EXPAND_BIT > 7) || (`PEP_EXPAND_BIT <= `PEP_MODE_MSB)) begin : g_bad_expand_bit
    $error("pep_port expansion flag must sit above the mode field");
  end
  if ((`PEP_WIDE_BUS_BIT > 7) || (`PEP_WIDE_BUS_BIT <= `PEP_MODE_MSB)) begin : g_bad_wide_bit
    $error("pep_port bus width flag must sit above the mode field");
  end
  if (`PEP_EXPAND_BIT == `PEP_WIDE_BUS_BIT) begin : g_same_flag_bit
    $error("pep_port expansion and bus width flags share one bit");
  end

  // =====================================================================
  // Registers
  logic [WIDTH-1:0] output_latch;
  logic [WIDTH-1:0] direction_bits;
  logic [WIDTH-1:0] pullup_enable;
  logic [7:0]       mode_ctrl;
  logic [WIDTH-1:0] next_output_latch;
  logic [WIDTH-1:0] next_direction_bits;
  logic [WIDTH-1:0] next_pullup_enable;
  logic [7:0]       next_mode_ctrl;
  logic [7:0]       next_reg_rdata;
  logic [WIDTH-1:0] pin_level_view;

  // =====================================================================
  // Address decode
  // One decode serves both strobes, so a read and a write of one offset
  // always agree on the register they mean
  logic hit_latch;
  logic hit_dir;
  logic hit_view;
  logic hit_pu;
  logic hit_mode;

  always_comb begin
    hit_latch = (reg_addr == `PEP_OFF_OUTPUT_LATCH);
    hit_dir   = (reg_addr == `PEP_OFF_DIRECTION_BITS);
    hit_view  = (reg_addr == `PEP_OFF_PIN_LEVEL_VIEW);
    hit_pu    = (reg_addr == `PEP_OFF_PULLUP_ENABLE);
    hit_mode  = (reg_addr == `PEP_OFF_MODE_CTRL);
  end

  // =====================================================================
  // Output latch: what a pin drives while it is a port output
  always_comb begin
    next_output_latch = output_latch;
    if (reg_wr && hit_latch) begin
      next_output_latch = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      output_latch <= `PEP_RST_OUTPUT_LATCH;
    end else begin
      output_latch <= next_output_latch;
    end
  end

  // =====================================================================
  // Direction bits: write-only, a read returns a fixed filler value
  // Software must keep its own copy; the filler never tracks the bits
  always_comb begin
    next_direction_bits = direction_bits;
    if (reg_wr && hit_dir) begin
      next_direction_bits = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      direction_bits <= `PEP_RST_DIRECTION_BITS;
    end else begin
      direction_bits <= next_direction_bits;
    end
  end

  // =====================================================================
  // Pull-up enable: plain read/write bits, gated by bus width below
  always_comb begin
    next_pullup_enable = pullup_enable;
    if (reg_wr && hit_pu) begin
      next_pullup_enable = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pullup_enable <= `PEP_RST_PULLUP_ENABLE;
    end else begin
      pullup_enable <= next_pullup_enable;
    end
  end

  // =====================================================================
  // Mode control: operating mode, expansion flag and bus width
  // Unused high bits are masked so that they always read back as zero
  always_comb begin
    next_mode_ctrl = mode_ctrl;
    if (reg_wr && hit_mode) begin
      next_mode_ctrl = reg_wdata & `PEP_MODE_CTRL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_ctrl <= `PEP_RST_MODE_CTRL;
    end else begin
      mode_ctrl <= next_mode_ctrl;
    end
  end

  // =====================================================================
  // Register reads
  // The view has no write branch above, so a write to its offset is lost
  // Read data stands only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd && hit_latch) begin
      next_reg_rdata = output_latch;
    end
    if (reg_rd && hit_dir) begin
      next_reg_rdata = `PEP_UNDEF_READ;
    end
    if (reg_rd && hit_view) begin
      next_reg_rdata = pin_level_view;
    end
    if (reg_rd && hit_pu) begin
      next_reg_rdata = pullup_enable;
    end
    if (reg_rd && hit_mode) begin
      next_reg_rdata = mode_ctrl;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // =====================================================================
  // Pin function selection
  logic [2:0] op_mode;
  logic       expand_en;
  logic       wide_bus;
  logic       single_chip;
  pep_fn_e    fn;
  pep_pwr_e   pwr;
  logic       next_data_mode;
  logic       pu_allowed;
  logic       mode_may_isolate;

  assign op_mode   = mode_ctrl[`PEP_MODE_MSB:`PEP_MODE_LSB];
  assign expand_en = mode_ctrl[`PEP_EXPAND_BIT];
  assign wide_bus  = mode_ctrl[`PEP_WIDE_BUS_BIT];

  // Only modes 3 and 7 may run with the external bus switched off; every
  // other mode, mode 0 included, always has it and ignores the flag
  always_comb begin
    unique case (op_mode)
      3'd3, 3'd7:                         mode_may_isolate = 1'b1;
      3'd0, 3'd1, 3'd2, 3'd4, 3'd5, 3'd6: mode_may_isolate = 1'b0;
    endcase
  end

  assign single_chip = mode_may_isolate && !expand_en;

  always_comb begin
    if (single_chip) begin
      fn = PEP_FN_PORT;
    end else if (wide_bus) begin
      fn = PEP_FN_DATA;
    end else begin
      fn = PEP_FN_PORT;
    end
  end

  // Hardware standby outranks software standby: every pull-up must drop
  always_comb begin
    if (hw_standby) begin
      pwr = PEP_PWR_HSBY;
    end else if (sw_standby) begin
      pwr = PEP_PWR_SSBY;
    end else begin
      pwr = PEP_PWR_RUN;
    end
  end

  assign next_data_mode = (fn == PEP_FN_DATA);

  // Hardware standby and width choice gate pull-ups; software standby keeps them as in run
  always_comb begin
    unique case (pwr)
      PEP_PWR_HSBY: pu_allowed = 1'b0;
      PEP_PWR_SSBY: pu_allowed = !wide_bus;
      PEP_PWR_RUN:  pu_allowed = !wide_bus;
      default:      pu_allowed = 1'b0;
    endcase
  end

  // Pins reach the bus controller one cycle late, as sampled here; the
  // view reads the same levels unregistered, so the two may differ briefly
  logic [WIDTH-1:0] next_bus_din;

  always_comb begin
    next_bus_din = pin_in;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_mode <= 1'b0;
      bus_din   <= '0;
    end else begin
      data_mode <= next_data_mode;
      bus_din   <= next_bus_din;
    end
  end

  // =====================================================================
  // Pin slices
  // Each slice registers its own drive and pull-up, so every pin leaves a flop
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    pep_bit u_bit (
      .mclk       (mclk),
      .rstn       (rstn),
      .latch_bit  (output_latch[i]),
      .dir_bit    (direction_bits[i]),
      .pu_bit     (pullup_enable[i]),
      .pin_in     (pin_in[i]),
      .data_mode  (next_data_mode),
      .pu_allowed (pu_allowed),
      .bus_out    (bus_dout[i]),
      .bus_oe     (bus_doe),
      .view_bit   (pin_level_view[i]),
      .pin_out    (pin_out[i]),
      .pin_oe     (pin_oe[i]),
      .pullup_on  (pullup_on[i])
    );
  end

endmodule : pep_port

`default_nettype wire

// ### bench/pep_port_monitor.sv
/*
  Port-level checker for pep_port.
  Assumes it is bound onto pep_port and sees only its ports.
*/
`default_nettype none

// ==========
// Checker
module pep_port_monitor (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       hw_standby,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] bus_dout,
  input wire logic       bus_doe,
  input wire logic       data_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] sh;
  logic [7:0]  lat;
  logic [7:0]  dir;
  logic [7:0]  pu;
  logic [7:0]  md;
  logic        dm;
  logic [7:0]  pux;
  // Shadow of the writable registers; slot 2 is the read-only view
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sh <= 40'h0;
    end else if (reg_wr && reg_addr[1:0] == 2'b00 && reg_addr < 8'h14 && reg_addr != 8'h08) begin
      sh[reg_addr[4:2]*8 +: 8] <= reg_wdata;
    end
  end
  assign lat = sh[7:0];
  assign dir = sh[15:8];
  assign pu  = sh[31:24];
  assign md  = sh[39:32];
  assign dm  = md[4] && !(md[1:0] == 2'b11 && !md[3]);
  assign pux = (hw_standby || md[4]) ? 8'h00 : (pu & ~dir);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  view_read_a: assert property (reg_rd && reg_addr == 8'h08 |=>
    reg_rdata == $past((dir & lat) | (~dir & pin_in))) else $error("view read wrong");
  pu_read_a: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == $past(pu))
    else $error("pull-up read wrong");
  dir_read_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00)
    else $error("direction read wrong");
  pullup_map_a: assert property (pullup_on == $past(pux))
    else $error("pull-up state wrong");
  hw_off_a: assert property (hw_standby |=> pullup_on == 8'h00)
    else $error("pull-up on in standby");
  mode_map_a: assert property (data_mode == $past(dm))
    else $error("pin function wrong");
  port_drive_a: assert property (!$past(data_mode) && !data_mode |->
    pin_oe == $past(dir) && pin_out == $past(lat)) else $error("port drive wrong");
  bus_drive_a: assert property ($past(data_mode) && data_mode |->
    pin_oe == {8{$past(bus_doe)}} && pin_out == $past(bus_dout)) else $error("bus drive wrong");
endmodule : pep_port_monitor

bind pep_port pep_port_monitor u_mon (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .hw_standby(hw_standby), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pullup_on(pullup_on), .bus_dout(bus_dout), .bus_doe(bus_doe), .data_mode(data_mode));

`default_nettype wire

// ### bench/pep_pins.sv
/*
  Pin model: resolves module drive, outside drive and pull-ups.
  Assumes one outside driver per pin, enabled by ext_en.
*/
`default_nettype none

// ==========
// Pins
module pep_pins (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pin shows its pull-up level, else the inverse of the outside value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_on | ~ext_val));
endmodule : pep_pins

`default_nettype wire

// ### bench/pep_port_bench.sv
/*
  Self-checking bench for pep_port with a pin model.
  Assumes pep_port_monitor is bound in the same compile.
*/
`default_nettype none

// ==========
// Bench
module pep_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, reg_wr, reg_rd, hw_standby, sw_standby, bus_doe, data_mode;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, pullup_on;
  logic [7:0]  bus_dout, bus_din, ext_val, ext_en, v, d, l, p, m;
  logic [31:0] r;
  integer      seed;
  int          err_count, tests_run, cycles;

  pep_port DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .bus_dout(bus_dout), .bus_doe(bus_doe), .bus_din(bus_din),
    .data_mode(data_mode));
  pep_pins u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  function automatic logic dmx(input logic [7:0] mc);
    return mc[4] && !(mc[1:0] == 2'b11 && !mc[3]);
  endfunction : dmx

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask : rd

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Loop needs about 1100 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 6000) begin
      err_count++;
      results;
    end
  end

  initial begin
    seed = 32'h3c7f70f4;
    {rstn, reg_wr, reg_rd, hw_standby, sw_standby, bus_doe} = 6'h0;
    {reg_addr, reg_wdata, bus_dout, ext_val, ext_en} = 40'h0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h0c, v); chk("pu_reset", v, 8'h00);
    rd(8'h00, v); chk("latch_reset", v, 8'h00);
    rd(8'h04, v); chk("dir_read", v, 8'h00);
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      d = $random(seed);
      l = $random(seed);
      p = $random(seed);
      m = (i < 32) ? 8'(i) : (8'($random(seed)) & 8'h1f);
      @(posedge mclk);
      {sw_standby, bus_doe, bus_dout, ext_val, ext_en} <= r[25:0];
      hw_standby <= r[28:26] == 3'h0;
      wr(8'h00, l);
      wr(8'h04, d);
      wr(8'h0c, p);
      wr(8'h10, m);
      wr(8'h08, ~l);
      repeat (2) @(posedge mclk);
      #1 chk("pullup", pullup_on, (hw_standby || m[4]) ? 8'h00 : (p & ~d));
      chk("data_mode", {7'h0, data_mode}, {7'h0, dmx(m)});
      chk("pin_oe", pin_oe, dmx(m) ? {8{bus_doe}} : d);
      chk("pin_out", pin_out, dmx(m) ? bus_dout : l);
      chk("bus_din", bus_din, pin_in);
      rd(8'h08, v); chk("view", v, (d & l) | (~d & pin_in));
      rd(8'h0c, v); chk("pu_read", v, p);
    end
    @(posedge mclk);
    hw_standby <= 1'b0;
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h0c, 8'hff);
    repeat (2) @(posedge mclk);
    #1 chk("pullup_all", pullup_on, 8'hff);
    @(posedge mclk);
    rstn <= 1'b0;
    #1 chk("pullup_reset", pullup_on, 8'h00);
    @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h0c, v); chk("pu_reset2", v, 8'h00);
    rd(8'h14, v); chk("unmapped", v, 8'h00);
    results;
  end
endmodule : pep_port_bench

`default_nettype wire
